// *** verilog/cpt_timer.sv ***
`timescale 1ns/1ps
// Operation
// R1: PWM mode: clearing run stops counter, clears to zero, pin returns to initial level.
// R2: External clock at most gear clock/2, each phase at least two machine cycles.
// R3: Buffer select bit 0 disables, 1 enables double buffering of compare values.
// R4: PWM buffered: running writes go to buffer; copied at every sixteenth overflow.
// R5: With buffering on, duty readback shows the buffered last-written value.
// R6: Buffered and stopped: high duty write loads buffer and active compare together.
// R7: Unbuffered running writes act immediately; smaller value waits for overflow wrap.
// R8: Unbuffered value equal to count matches right after the write.
// R9: Low period, high period, low duty written first; high duty write commits all.
// R10: Cascade bit joins timers into one 16-bit counter; high timer settings rule.
// R11: Operating mode field 11 selects the 16-bit pulse generator.
// R12: External source bit 0 uses internal divider tap, 1 uses external pin.
// R13: Clock select taps 2^11,2^10,2^8,2^6,2^4,2^2,2,1; slow taps 16,8,4.
// R14: PPG: duty match toggles output away from initial level, raises low irq.
// R15: PPG: period match returns output to initial level, high irq, counter clears.
// R16: Stopped: output pin shows the initial level bit.
// R17: PPG: clearing run stops counter, clears to zero, output to initial level.
// R18: PWM: low byte compared to duty; wrap at 256 toggles, irq each and sixteenth.
// R19: Extra pulse bits lengthen duty in fixed cycles of each 16-cycle frame.
// R20: PPG buffered: buffered values move to active at period match with high irq.
// R21: Mode register writes are ignored while the counter runs.
module cpt_timer (
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_slow_clk_tick,
  input wire logic i_slow_divider_select,
  input wire logic i_ext_clk_pin,
  input wire logic i_cascade_bit,
  input wire logic i_high_run_bit,
  input wire logic i_mode_wr,
  input wire logic [1:0] i_operating_mode_field,
  input wire logic i_external_source_bit,
  input wire logic [2:0] i_clock_select_field,
  input wire logic i_buffer_select_bit,
  input wire logic i_initial_level_bit,
  input wire logic i_period_low_wr,
  input wire logic i_period_high_wr,
  input wire logic i_duty_low_wr,
  input wire logic i_duty_high_wr,
  input wire logic [7:0] i_wdata,
  output logic [15:0] o_duty_readback,
  output logic [15:0] o_period_readback,
  output logic [15:0] o_count,
  output logic o_running,
  output logic o_pwm_out_pin,
  output logic o_pulse_gen_out_pin,
  output logic o_low_timer_irq,
  output logic o_high_timer_irq
);
  import cpt_pkg::*;

  // ==========================================================
  // Mode register
  logic [1:0] mode_q;
  logic ext_q;
  logic [2:0] tck_q;
  logic dbe_q;
  logic tff_q;
  logic run_q;
  logic active;
  assign active = run_q && i_cascade_bit; // see R10

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= 2'h0;
      ext_q <= 1'b0;
      tck_q <= 3'h0;
      dbe_q <= 1'b0;
      tff_q <= 1'b0;
    end else if (i_mode_wr && !run_q) begin // see R21
      mode_q <= i_operating_mode_field;
      ext_q <= i_external_source_bit;
      tck_q <= i_clock_select_field;
      dbe_q <= i_buffer_select_bit; // see R3
      tff_q <= i_initial_level_bit;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run_q <= 1'b0;
    end else begin
      run_q <= i_high_run_bit;
    end
  end

  // ==========================================================
  // Source clock selection
  logic [PRE_W-1:0] pre_q;
  logic [SLOW_PRE_W-1:0] slow_pre_q;
  logic [SYNC_STAGES-1:0] ext_sync_q;
  logic ext_last_q;
  logic src_tick;
  logic int_tick;
  logic slow_sel;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pre_q <= '0;
      slow_pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
      if (i_slow_clk_tick) begin
        slow_pre_q <= slow_pre_q + 1'b1;
      end
    end
  end

  // First stage feeds only the second; edge detect looks at stage two
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_sync_q <= '0;
      ext_last_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], i_ext_clk_pin}; // see R2
      ext_last_q <= ext_sync_q[1];
    end
  end

  // Tick when the low (n) bits of a free counter wrap to all ones
  function automatic logic tap(input logic [PRE_W-1:0] cnt, input int n);
    logic [PRE_W-1:0] m;
    m = PRE_W'((1 << n) - 1);
    return (cnt & m) == m;
  endfunction

  assign slow_sel = i_slow_divider_select && (tck_q == 3'h0 || tck_q == 3'h1 || tck_q == 3'h7);

  always_comb begin
    int_tick = 1'b0;
    if (slow_sel) begin // see R13
      case (tck_q)
        3'h0: int_tick = i_slow_clk_tick && slow_pre_q == 4'hF;
        3'h1: int_tick = i_slow_clk_tick && slow_pre_q[2:0] == 3'h7;
        default: int_tick = i_slow_clk_tick && slow_pre_q[1:0] == 2'h3;
      endcase
    end else begin
      case (tck_q)
        3'h0: int_tick = tap(pre_q, 11);
        3'h1: int_tick = tap(pre_q, 10);
        3'h2: int_tick = tap(pre_q, 8);
        3'h3: int_tick = tap(pre_q, 6);
        3'h4: int_tick = tap(pre_q, 4);
        3'h5: int_tick = tap(pre_q, 2);
        3'h6: int_tick = tap(pre_q, 1);
        default: int_tick = 1'b1;
      endcase
    end
  end

  assign src_tick = ext_q ? (ext_sync_q[1] && !ext_last_q) : int_tick; // see R12

  // ==========================================================
  // Staging and compare registers
  logic [7:0] per_lo_q;
  logic [7:0] per_hi_q;
  logic [7:0] duty_lo_q;
  logic [15:0] buf_duty_q;
  logic [15:0] buf_per_q;
  logic [15:0] act_duty_q;
  logic [15:0] act_per_q;
  logic commit;
  logic reload;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      per_lo_q <= REG_RESET;
      per_hi_q <= REG_RESET;
      duty_lo_q <= REG_RESET;
    end else begin
      if (i_period_low_wr) begin
        per_lo_q <= i_wdata;
      end
      if (i_period_high_wr) begin
        per_hi_q <= i_wdata;
      end
      if (i_duty_low_wr) begin
        duty_lo_q <= i_wdata;
      end
    end
  end

  assign commit = i_duty_high_wr; // see R9

  // Byte pair to compare word; the buffer and the active compare load the same words
  function automatic logic [15:0] join_bytes(input logic [7:0] hi, input logic [7:0] lo);
    return {hi, lo};
  endfunction

  logic [15:0] commit_duty;
  logic [15:0] commit_per;
  // The high duty byte rides on the strobe itself, so it never sits in a staging register
  assign commit_duty = join_bytes(i_wdata, duty_lo_q);
  assign commit_per = join_bytes(per_hi_q, per_lo_q);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      buf_duty_q <= {REG_RESET, REG_RESET};
      buf_per_q <= {REG_RESET, REG_RESET};
    end else if (commit) begin
      buf_duty_q <= commit_duty;
      buf_per_q <= commit_per;
    end
  end

  // Active compares: immediate when unbuffered or stopped, else at reload
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_duty_q <= {REG_RESET, REG_RESET};
      act_per_q <= {REG_RESET, REG_RESET};
    end else if (commit && (!dbe_q || !active)) begin // see R6, R7
      act_duty_q <= commit_duty;
      act_per_q <= commit_per;
    end else if (reload) begin // see R4, R20
      act_duty_q <= buf_duty_q;
      act_per_q <= buf_per_q;
    end
  end

  // Readback shows the last committed buffer word, one cycle behind the buffer
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_duty_readback <= {REG_RESET, REG_RESET};
      o_period_readback <= {REG_RESET, REG_RESET};
    end else begin
      o_duty_readback <= buf_duty_q; // see R5
      o_period_readback <= buf_per_q;
    end
  end

  // ==========================================================
  // Counter and match logic
  logic [15:0] cnt_q;
  logic [3:0] frame_q;
  logic lvl_q;
  logic is_ppg;
  logic is_pwm;
  logic extra;
  logic [8:0] duty_end;
  logic pwm_match;
  logic pwm_wrap;
  logic ppg_duty_match;
  logic ppg_per_match;

  assign is_ppg = mode_q == MODE_PPG16; // see R11
  assign is_pwm = mode_q == MODE_PWM12;

  // Frame cycle k+1 gets an extra count per the bit pattern
  always_comb begin
    extra = 1'b0;
    if (frame_q[0]) begin
      extra = act_duty_q[3]; // see R19
    end else if (frame_q[1:0] == 2'h2) begin
      extra = act_duty_q[2];
    end else if (frame_q[2:0] == 3'h4) begin
      extra = act_duty_q[1];
    end else if (frame_q == 4'h8) begin
      extra = act_duty_q[0];
    end
  end

  assign duty_end = {1'b0, act_duty_q[11:4]} + {8'h00, extra};
  // Compare is live on the current count, so an equal write matches at once
  assign pwm_match = active && is_pwm && {1'b0, cnt_q[7:0]} == duty_end; // see R8, R18
  assign pwm_wrap = active && is_pwm && src_tick && cnt_q[7:0] == 8'hFF;
  assign ppg_duty_match = active && is_ppg && cnt_q == act_duty_q; // see R14
  assign ppg_per_match = active && is_ppg && src_tick && cnt_q == act_per_q;
  assign reload = dbe_q && ((pwm_wrap && frame_q == FRAME_LAST) || ppg_per_match);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= CNT_CLEAR;
      frame_q <= 4'h0;
    end else if (!active) begin
      cnt_q <= CNT_CLEAR; // see R1, R17
      frame_q <= 4'h0;
    end else if (ppg_per_match) begin
      cnt_q <= CNT_CLEAR; // see R15
    end else if (pwm_wrap) begin
      cnt_q <= CNT_CLEAR; // see R18
      frame_q <= frame_q + 1'b1;
    end else if (src_tick) begin
      cnt_q <= cnt_q + 1'b1; // see R7
    end
  end

  // Output level relative to initial level: 1 means toggled
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lvl_q <= 1'b0;
    end else if (!active || ppg_per_match || pwm_wrap) begin
      lvl_q <= 1'b0; // see R15, R16
    end else if (pwm_match || ppg_duty_match) begin
      lvl_q <= 1'b1; // see R14
    end
  end

  logic ppg_duty_hit_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ppg_duty_hit_q <= 1'b0;
    end else begin
      ppg_duty_hit_q <= ppg_duty_match && !lvl_q;
    end
  end


  // ==========================================================
  // Output stage
  // Pins lag lvl_q by one register stage, while the irqs fire with the lvl_q update
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pwm_out_pin <= 1'b0;
      o_pulse_gen_out_pin <= 1'b0;
    end else begin
      o_pwm_out_pin <= tff_q ^ lvl_q; // see R16
      o_pulse_gen_out_pin <= tff_q ^ lvl_q;
    end
  end

  // Duty irq fires once per match, even if an equal write re-hits the same count
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_low_timer_irq <= 1'b0;
      o_high_timer_irq <= 1'b0;
    end else begin
      o_low_timer_irq <= pwm_wrap || (ppg_duty_match && !lvl_q && !ppg_duty_hit_q); // see R14, R18
      o_high_timer_irq <= (pwm_wrap && frame_q == FRAME_LAST) || ppg_per_match; // see R4, R15
    end
  end

  // Status view is one cycle behind the internal counter
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_count <= CNT_CLEAR;
      o_running <= 1'b0;
    end else begin
      o_count <= cnt_q;
      o_running <= active;
    end
  end
endmodule // cpt_timer

// *** shared/cpt_pkg.sv ***
package cpt_pkg;
  localparam int CNT_W = 16;
  localparam int DUTY_W = 8;
  localparam int XP_W = 4;
  localparam logic [1:0] MODE_PWM12 = 2'h2;
  localparam logic [1:0] MODE_PPG16 = 2'h3;
  localparam logic [15:0] CNT_CLEAR = 16'h0000;
  localparam logic [7:0] REG_RESET = 8'hFF;
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam int PRE_W = 11;
  localparam int SLOW_PRE_W = 4;
  localparam int SYNC_STAGES = 2;
endpackage

// *** tb/cpt_timer_props.sv ***
`timescale 1ns/1ps
// ==========
// Port checker
module cpt_timer_props
  import cpt_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  input wire logic i_mode_wr,
  input wire logic [1:0] i_operating_mode_field,
  input wire logic i_initial_level_bit,
  input wire logic i_period_low_wr,
  input wire logic i_period_high_wr,
  input wire logic i_duty_low_wr,
  input wire logic i_duty_high_wr,
  input wire logic [7:0] i_wdata,
  input wire logic [15:0] o_duty_readback,
  input wire logic [15:0] o_period_readback,
  input wire logic [15:0] o_count,
  input wire logic o_running,
  input wire logic o_pwm_out_pin,
  input wire logic o_pulse_gen_out_pin,
  input wire logic o_low_timer_irq,
  input wire logic o_high_timer_irq
);
  logic [7:0] dl_q, pl_q, ph_q;
  logic [1:0] mode_q;
  logic lvl_q;
  logic [3:0] ovf_q;
  // Shadow follows only stopped writes, since running writes are dropped
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= 2'h0;
      lvl_q <= 1'b0;
    end else if (i_mode_wr && !o_running) begin
      mode_q <= i_operating_mode_field;
      lvl_q <= i_initial_level_bit;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dl_q <= REG_RESET;
      pl_q <= REG_RESET;
      ph_q <= REG_RESET;
    end else begin
      if (i_duty_low_wr) dl_q <= i_wdata;
      if (i_period_low_wr) pl_q <= i_wdata;
      if (i_period_high_wr) ph_q <= i_wdata;
    end
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) ovf_q <= 4'h0;
    else if (!o_running) ovf_q <= 4'h0;
    else if (o_low_timer_irq) ovf_q <= ovf_q + 4'h1;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  stop_level_a: assert property (!o_running && $past(!o_running, 2) && !$past(i_mode_wr)
    && !$past(i_mode_wr, 2) |-> o_pulse_gen_out_pin == lvl_q) else $error("stopped pin not at initial level");
  stopped_zero_a: assert property (!o_running && $past(!o_running, 2) |-> o_count == CNT_CLEAR)
    else $error("stopped counter not cleared");
  pins_same_a: assert property (o_pwm_out_pin == o_pulse_gen_out_pin) else $error("output pins differ");
  irq_running_a: assert property ((o_low_timer_irq || o_high_timer_irq) |-> $past(o_running))
    else $error("irq while stopped");
  duty_commit_a: assert property (i_duty_high_wr ##2 1 |-> o_duty_readback == {$past(i_wdata, 2), dl_q})
    else $error("duty readback wrong after commit");
  period_commit_a: assert property (i_duty_high_wr ##2 1 |-> o_period_readback == {ph_q, pl_q})
    else $error("period readback wrong after commit");
  readback_hold_a: assert property (!$past(i_duty_high_wr, 2) |-> $stable(o_duty_readback))
    else $error("duty readback moved without commit");
  ppg_duty_a: assert property (mode_q == MODE_PPG16 && o_low_timer_irq |-> ##1 o_pulse_gen_out_pin != lvl_q)
    else $error("duty match level wrong");
  ppg_period_a: assert property (mode_q == MODE_PPG16 && o_high_timer_irq |-> ##1 o_pulse_gen_out_pin == lvl_q)
    else $error("period match level wrong");
  pwm_sixteen_a: assert property (mode_q == MODE_PWM12 && o_high_timer_irq |-> o_low_timer_irq
    && ovf_q == FRAME_LAST) else $error("high irq not on sixteenth overflow");
endmodule // cpt_timer_props
bind cpt_timer cpt_timer_props cpt_timer_props_i (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
  .i_mode_wr(i_mode_wr), .i_operating_mode_field(i_operating_mode_field), .i_initial_level_bit(i_initial_level_bit),
  .i_period_low_wr(i_period_low_wr), .i_period_high_wr(i_period_high_wr), .i_duty_low_wr(i_duty_low_wr),
  .i_duty_high_wr(i_duty_high_wr), .i_wdata(i_wdata), .o_duty_readback(o_duty_readback),
  .o_period_readback(o_period_readback), .o_count(o_count), .o_running(o_running), .o_pwm_out_pin(o_pwm_out_pin),
  .o_pulse_gen_out_pin(o_pulse_gen_out_pin), .o_low_timer_irq(o_low_timer_irq), .o_high_timer_irq(o_high_timer_irq));

// *** tb/cpt_load_model.sv ***
`timescale 1ns/1ps
// ==========
// Load on the pulse pin, plus external count clock source
module cpt_load_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_pin,
  input wire logic i_ext_en,
  output logic o_ext_clk,
  output int o_hi_len,
  output int o_lo_len,
  output int o_edges
);
  int run_q;
  logic last_q;
  logic [1:0] div_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_q <= 1'b0;
      run_q <= 0;
      o_edges <= 0;
      o_hi_len <= 0;
      o_lo_len <= 0;
    end else begin
      last_q <= i_pin;
      run_q <= (i_pin != last_q) ? 1 : run_q + 1;
      if (i_pin != last_q) o_edges <= o_edges + 1;
      if (i_pin != last_q && last_q) o_hi_len <= run_q;
      if (i_pin != last_q && !last_q) o_lo_len <= run_q;
    end
  end
  // Four cycles per phase: slower than gear/2 and well over two cycles wide; idles low when unused
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) div_q <= 2'h0;
    else div_q <= i_ext_en ? div_q + 2'h1 : 2'h0;
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_ext_clk <= 1'b0;
    else o_ext_clk <= i_ext_en && (o_ext_clk ^ (div_q == 2'h3));
  end
endmodule // cpt_load_model

// *** tb/tb_cpt_timer.sv ***
`timescale 1ns/1ps
module tb_cpt_timer;
  import cpt_pkg::*;
  typedef struct {logic [2:0] cs; logic e; logic l; logic [15:0] p; logic [15:0] d;} cpt_row_s;
  cpt_row_s rows[5] = '{'{3'h7, 1'b0, 1'b0, 16'h0010, 16'h0004}, '{3'h6, 1'b0, 1'b1, 16'h000C, 16'h0008},
    '{3'h5, 1'b0, 1'b0, 16'h0009, 16'h0004}, '{3'h7, 1'b1, 1'b0, 16'h0006, 16'h0002},
    '{3'h7, 1'b0, 1'b1, 16'h0105, 16'h0100}};
  int divtab[8] = '{2048, 1024, 256, 64, 16, 4, 2, 1};
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, mwr = 1'b0, ext = 1'b0, bsel = 1'b0, lvl = 1'b0, ext_en = 1'b0;
  logic cas = 1'b1, sdsel = 1'b0, slow_on = 1'b0, stick = 1'b0;
  logic [1:0] mode = 2'h0;
  logic [2:0] csel = 3'h0;
  logic [3:0] st = 4'h0;
  logic [7:0] wd = 8'h00;
  logic ext_clk, pwm_pin, ppg_pin, lirq, hirq, running;
  logic [15:0] duty_rb, per_rb, count;
  int hi_len, lo_len, edges, failures = 0, total_checks = 0, cycles = 0, e0, k;
  cpt_timer cpt_timer_i (.i_core_clk(clk), .i_rst_n(rst_n), .i_slow_clk_tick(stick), .i_slow_divider_select(sdsel),
    .i_ext_clk_pin(ext_clk), .i_cascade_bit(cas), .i_high_run_bit(run), .i_mode_wr(mwr),
    .i_operating_mode_field(mode), .i_external_source_bit(ext), .i_clock_select_field(csel),
    .i_buffer_select_bit(bsel), .i_initial_level_bit(lvl), .i_period_low_wr(st[0]), .i_period_high_wr(st[1]),
    .i_duty_low_wr(st[2]), .i_duty_high_wr(st[3]), .i_wdata(wd), .o_duty_readback(duty_rb),
    .o_period_readback(per_rb), .o_count(count), .o_running(running), .o_pwm_out_pin(pwm_pin),
    .o_pulse_gen_out_pin(ppg_pin), .o_low_timer_irq(lirq), .o_high_timer_irq(hirq));
  cpt_load_model cpt_load_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_pin(ppg_pin), .i_ext_en(ext_en),
    .o_ext_clk(ext_clk), .o_hi_len(hi_len), .o_lo_len(lo_len), .o_edges(edges));
  always #4 clk = ~clk;
  // Slow clock tick every second cycle when enabled
  always @(posedge clk) #1 stick = slow_on && !stick;
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic setmode(input logic [1:0] m, input logic e, input logic [2:0] c, input logic b, input logic l);
    mode = m;
    ext = e;
    csel = c;
    bsel = b;
    lvl = l;
    mwr = 1'b1;
    cyc(1);
    mwr = 1'b0;
    cyc(1);
  endtask
  task automatic wr(input int n, input logic [7:0] v);
    st = 4'h1 << n;
    wd = v;
    cyc(1);
  endtask
  task automatic load(input logic [15:0] p, input logic [15:0] d);
    wr(0, p[7:0]);
    wr(1, p[15:8]);
    wr(2, d[7:0]);
    wr(3, d[15:8]);
    st = 4'h0;
    cyc(2);
  endtask
  task automatic wait_edges(input int n);
    e0 = edges;
    for (k = 0; k < 6000 && edges < e0 + n; k++) cyc(1);
  endtask
  task automatic stopchk(input logic l);
    run = 1'b0;
    cyc(4);
    chk(ppg_pin, l);
    chk(count, CNT_CLEAR);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    cyc(5);
    rst_n = 1'b1;
    cyc(1);
    chk(duty_rb, 16'hFFFF);
    chk(ppg_pin, 1'b0);
    foreach (rows[i]) begin
      setmode(MODE_PPG16, rows[i].e, rows[i].cs, 1'b0, rows[i].l);
      ext_en = rows[i].e;
      load(rows[i].p, rows[i].d);
      chk(duty_rb, rows[i].d);
      chk(per_rb, rows[i].p);
      run = 1'b1;
      wait_edges(2);
      chk(rows[i].l ? lo_len : hi_len, (rows[i].p - rows[i].d + 1) * (rows[i].e ? 8 : divtab[rows[i].cs]) - 1);
      stopchk(rows[i].l);
      ext_en = 1'b0;
    end
    // Slow tap 111 counts every fourth slow tick, eight core cycles here
    sdsel = 1'b1;
    slow_on = 1'b1;
    setmode(MODE_PPG16, 1'b0, 3'h7, 1'b0, 1'b0);
    load(16'h0006, 16'h0002);
    run = 1'b1;
    wait_edges(2);
    chk(hi_len, 39);
    stopchk(1'b0);
    sdsel = 1'b0;
    slow_on = 1'b0;
    // Buffered PWM: a running write must wait for the sixteenth wrap
    setmode(MODE_PWM12, 1'b0, 3'h7, 1'b1, 1'b0);
    load(16'h0000, 16'h0C00);
    run = 1'b1;
    wait_edges(2);
    chk(hi_len, 63);
    load(16'h0000, 16'h0800);
    chk(duty_rb, 16'h0800);
    wait_edges(2);
    chk(hi_len, 63);
    for (k = 0; k < 5000 && hirq !== 1'b1; k++) cyc(1);
    wait_edges(4);
    chk(hi_len, 127);
    setmode(MODE_PPG16, 1'b0, 3'h7, 1'b0, 1'b1);
    stopchk(1'b0);
    // Without the cascade bit the joined counter must not run
    cas = 1'b0;
    run = 1'b1;
    cyc(4);
    chk(running, 1'b0);
    chk(count, CNT_CLEAR);
    run = 1'b0;
    cas = 1'b1;
    cyc(2);
    stop_test();
  end
endmodule // tb_cpt_timer
